// File: src/sample_sequencer_compare.sv
// Sample sequencer with window and hysteresis comparison, Wishbone slave
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/100ps
module sample_sequencer_compare #(
  parameter int THR_W = seq_pkg::THR_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Trigger from the timing generator (same clock)
  input wire logic trigger_pulse_i,
  // Measurements
  input wire logic [THR_W-1:0] amplitude_result_i,
  input wire logic [THR_W-1:0] range_bin_index_i,
  input wire logic [THR_W-1:0] dealias_phase_i,
  input wire logic [THR_W-1:0] phase_i,
  // Results
  output logic compare_status_o,
  output logic [seq_pkg::OUT_W-1:0] control_bits_o,
  output logic irq_o
);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [seq_pkg::REG_W-1:0] compare_cfg_reg;
  logic [seq_pkg::REG_W-1:0] seq_ctrl_reg;
  logic [seq_pkg::CMD_W-1:0] slot_reg [seq_pkg::NUM_SLOTS];
  logic [seq_pkg::OUT_W-1:0] override_base_reg;
  logic [seq_pkg::OUT_W-1:0] status_word_reg;
  logic [seq_pkg::IRQ_W-1:0] irq_status_reg;
  logic [seq_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [4:0] pc_reg;
  logic [7:0] nop_count_reg;
  logic compare_status_reg;
  logic run_prev_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  logic [2:0] select;
  logic [THR_W-1:0] lower_threshold;
  logic [THR_W-1:0] upper_threshold;
  logic run_enable;
  logic override_enable;
  logic flow_condition;
  logic trigger_disable;
  logic step;
  logic [seq_pkg::CMD_W-1:0] command;
  logic [3:0] opcode;
  logic [7:0] operand;
  logic ge_lower;
  logic le_lower;
  logic le_upper;
  logic ge_upper;
  logic status_next;
  logic [4:0] pc_next;
  logic [7:0] nop_next;
  logic [seq_pkg::OUT_W-1:0] word_next;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [seq_pkg::IRQ_W-1:0] irq_events;

  // ------------------------------------------------------------
  // Field extraction
  // ------------------------------------------------------------
  assign select = compare_cfg_reg[seq_pkg::SEL_LSB +: 3];
  assign lower_threshold = compare_cfg_reg[seq_pkg::LOWER_LSB +: THR_W];
  assign upper_threshold = seq_ctrl_reg[seq_pkg::UPPER_LSB +: THR_W];
  assign run_enable = seq_ctrl_reg[seq_pkg::RUN_BIT];
  assign override_enable = seq_ctrl_reg[seq_pkg::OVERRIDE_BIT];
  assign flow_condition = seq_ctrl_reg[seq_pkg::FLOW_BIT];
  assign trigger_disable = seq_ctrl_reg[seq_pkg::TRIG_DIS_BIT];

  // Trigger gated by disable bit; run enable assumed stable while it pulses
  assign step = trigger_pulse_i && !trigger_disable && run_enable;

  assign command = slot_reg[pc_reg];
  assign opcode = command[seq_pkg::CMD_W-1 -: 4];
  assign operand = command[7:0];

  // ------------------------------------------------------------
  // Comparison datapath
  // ------------------------------------------------------------
  seq_compare_unit #(
    .W(THR_W)
  ) u_compare (
    .amplitude_result_i(amplitude_result_i),
    .range_bin_index_i(range_bin_index_i),
    .dealias_phase_i(dealias_phase_i),
    .phase_i(phase_i),
    .select_i(select),
    .lower_i(lower_threshold),
    .upper_i(upper_threshold),
    .at_or_above_lower_o(ge_lower),
    .at_or_below_lower_o(le_lower),
    .at_or_below_upper_o(le_upper),
    .at_or_above_upper_o(ge_upper)
  );

  // Jump targets beyond the last slot wrap to slot 0
  function automatic logic [4:0] target(input logic [7:0] op);
    if (op < 8'(seq_pkg::NUM_SLOTS)) begin
      target = op[4:0];
    end else begin
      target = 5'h00;
    end
  endfunction

  // ------------------------------------------------------------
  // Command execution
  // ------------------------------------------------------------
  always_comb begin
    status_next = compare_status_reg;
    pc_next = pc_reg;
    nop_next = nop_count_reg;
    word_next = status_word_reg;
    unique case (opcode)
      seq_pkg::OP_NOP: begin
        if (nop_count_reg >= operand) begin
          nop_next = 8'h00;
          pc_next = target(8'(pc_reg) + 8'h01);
        end else begin
          nop_next = nop_count_reg + 8'h01;
        end
      end
      seq_pkg::OP_WRITE: begin
        word_next = operand;
        pc_next = target(8'(pc_reg) + 8'h01);
      end
      seq_pkg::OP_GOTO: begin
        pc_next = target(operand);
      end
      seq_pkg::OP_COND_GOTO: begin
        if (flow_condition) begin
          pc_next = target(operand);
        end
      end
      seq_pkg::OP_WINDOW: begin
        status_next = ge_lower && le_upper;
      end
      seq_pkg::OP_HYST: begin
        if (le_lower) begin
          status_next = 1'b0;
        end else if (ge_upper) begin
          status_next = 1'b1;
        end
      end
      // Unsupported or invalid opcodes stall on the same slot
      default: begin
        pc_next = pc_reg;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_prev_reg <= 1'b0;
    end else begin
      run_prev_reg <= run_enable;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || (run_enable && !run_prev_reg) || !run_enable) begin
      pc_reg <= 5'h00;
      nop_count_reg <= 8'h00;
      compare_status_reg <= 1'b0;
      status_word_reg <= 8'h00;
    end else if (step) begin
      pc_reg <= pc_next;
      nop_count_reg <= nop_next;
      compare_status_reg <= status_next;
      status_word_reg <= word_next;
    end
  end

  assign compare_status_o = compare_status_reg;
  // Status word replaces register values only when override is set
  assign control_bits_o = override_enable ? status_word_reg
                                          : override_base_reg;

  // ------------------------------------------------------------
  // Wishbone slave: one wait state, ack dropped after one cycle
  // ------------------------------------------------------------
  assign bus_req = cyc_i && stb_i && !ack_reg;
  assign bus_wr = bus_req && we_i;
  assign bus_rd = bus_req && !we_i;

  function automatic logic [seq_pkg::REG_W-1:0] merge(
    input logic [seq_pkg::REG_W-1:0] old,
    input logic [31:0] data,
    input logic [3:0] lanes
  );
    merge = old;
    for (int i = 0; i < 3; i++) begin
      if (lanes[i]) begin
        merge[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end
  assign ack_o = ack_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_cfg_reg <= seq_pkg::RESET_REG;
      seq_ctrl_reg <= seq_pkg::RESET_REG;
      override_base_reg <= 8'h00;
      irq_mask_reg <= seq_pkg::RESET_IRQ;
    end else if (bus_wr) begin
      if (adr_i == seq_pkg::IDX_COMPARE_CFG) begin
        compare_cfg_reg <= merge(compare_cfg_reg, dat_i, sel_i);
      end
      if (adr_i == seq_pkg::IDX_SEQ_CTRL) begin
        seq_ctrl_reg <= merge(seq_ctrl_reg, dat_i, sel_i);
      end
      if (adr_i == seq_pkg::IDX_OVERRIDE_BASE && sel_i[0]) begin
        override_base_reg <= dat_i[7:0];
      end
      if (adr_i == seq_pkg::IDX_IRQ_MASK && sel_i[0]) begin
        irq_mask_reg <= dat_i[seq_pkg::IRQ_W-1:0];
      end
    end
  end

  // Addressed slot pair with the write lanes merged in
  logic [seq_pkg::REG_W-1:0] slot_pair;
  always_comb begin
    slot_pair = '0;
    for (int i = 0; i < seq_pkg::NUM_SLOTS / 2; i++) begin
      if (adr_i == seq_pkg::IDX_SLOT_FIRST + 8'(i)) begin
        slot_pair = merge({slot_reg[2*i+1], slot_reg[2*i]}, dat_i, sel_i);
      end
    end
  end

  // Program store: slot 2k low half, slot 2k+1 high half
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < seq_pkg::NUM_SLOTS; i++) begin
        slot_reg[i] <= 12'h000;
      end
    end else if (bus_wr && adr_i >= seq_pkg::IDX_SLOT_FIRST &&
                 adr_i <= seq_pkg::IDX_SLOT_LAST) begin
      for (int i = 0; i < seq_pkg::NUM_SLOTS / 2; i++) begin
        if (adr_i == seq_pkg::IDX_SLOT_FIRST + 8'(i)) begin
          slot_reg[2*i] <= slot_pair[seq_pkg::CMD_W-1:0];
          slot_reg[2*i+1] <=
            slot_pair[seq_pkg::SLOT_HI_LSB +: seq_pkg::CMD_W];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt status: set wins over clear-on-read
  // ------------------------------------------------------------
  assign irq_events[seq_pkg::IRQ_RISE] = status_next && !compare_status_reg
                                         && step && run_prev_reg;
  assign irq_events[seq_pkg::IRQ_FALL] = !status_next && compare_status_reg
                                         && step && run_prev_reg;
  assign irq_events[seq_pkg::IRQ_STEP] = step && run_prev_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_reg <= seq_pkg::RESET_IRQ;
    end else if (bus_rd && adr_i == seq_pkg::IDX_IRQ_STATUS) begin
      irq_status_reg <= irq_events;
    end else begin
      irq_status_reg <= irq_status_reg | irq_events;
    end
  end
  assign irq_o = |(irq_status_reg & irq_mask_reg);

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h00000000;
    end else if (bus_rd) begin
      rdata_reg <= 32'h00000000;
      if (adr_i == seq_pkg::IDX_COMPARE_CFG) begin
        rdata_reg <= {8'h00, compare_cfg_reg};
      end
      if (adr_i == seq_pkg::IDX_SEQ_CTRL) begin
        rdata_reg <= {8'h00, seq_ctrl_reg};
      end
      for (int i = 0; i < seq_pkg::NUM_SLOTS / 2; i++) begin
        if (adr_i == seq_pkg::IDX_SLOT_FIRST + 8'(i)) begin
          rdata_reg <= {8'h00, slot_reg[2*i+1], slot_reg[2*i]};
        end
      end
      if (adr_i == seq_pkg::IDX_OVERRIDE_BASE) begin
        rdata_reg <= {24'h000000, override_base_reg};
      end
      if (adr_i == seq_pkg::IDX_SEQ_STATUS) begin
        rdata_reg <= {16'h0000, status_word_reg, 2'h0, pc_reg,
                      compare_status_reg};
      end
      if (adr_i == seq_pkg::IDX_IRQ_STATUS) begin
        rdata_reg <= {29'h00000000, irq_status_reg};
      end
      if (adr_i == seq_pkg::IDX_IRQ_MASK) begin
        rdata_reg <= {29'h00000000, irq_mask_reg};
      end
    end
  end
  assign dat_o = rdata_reg;
endmodule

// File: src/seq_compare_unit.sv
// Comparison datapath: input select and threshold tests
`timescale 1ns/100ps
module seq_compare_unit #(
  parameter int W = 16
) (
  // Measurements
  input wire logic [W-1:0] amplitude_result_i,
  input wire logic [W-1:0] range_bin_index_i,
  input wire logic [W-1:0] dealias_phase_i,
  input wire logic [W-1:0] phase_i,
  // Settings
  input wire logic [2:0] select_i,
  input wire logic [W-1:0] lower_i,
  input wire logic [W-1:0] upper_i,
  // Results
  output logic at_or_above_lower_o,
  output logic at_or_below_lower_o,
  output logic at_or_below_upper_o,
  output logic at_or_above_upper_o
);
  logic [W-1:0] value;

  always_comb begin
    unique case (select_i)
      seq_pkg::SRC_AMPLITUDE: value = amplitude_result_i;
      seq_pkg::SRC_BIN: value = range_bin_index_i;
      seq_pkg::SRC_DEALIAS_PHASE: value = dealias_phase_i;
      seq_pkg::SRC_PHASE: value = phase_i;
      // Codes above 3 are undefined; amplitude is the safe choice
      default: value = amplitude_result_i;
    endcase
  end

  assign at_or_above_lower_o = value >= lower_i;
  assign at_or_below_lower_o = value <= lower_i;
  assign at_or_below_upper_o = value <= upper_i;
  assign at_or_above_upper_o = value >= upper_i;
endmodule

// File: src/seq_pkg.sv
// Package: register map, command encodings and reset values of the sequencer
package seq_pkg;
  // ------------------------------------------------------------
  // Register indexes (byte address = 4 * index)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_COMPARE_CFG = 8'h13;
  localparam logic [7:0] IDX_SEQ_CTRL = 8'h14;
  localparam logic [7:0] IDX_SLOT_FIRST = 8'h15;
  localparam logic [7:0] IDX_SLOT_LAST = 8'h1e;
  localparam logic [7:0] IDX_OVERRIDE_BASE = 8'h20;
  localparam logic [7:0] IDX_SEQ_STATUS = 8'h21;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h22;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h23;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int SEL_LSB = 0;
  localparam int LOWER_LSB = 3;
  localparam int UPPER_LSB = 0;
  localparam int RUN_BIT = 16;
  localparam int OVERRIDE_BIT = 17;
  localparam int FLOW_BIT = 18;
  localparam int TRIG_DIS_BIT = 19;
  localparam int SLOT_HI_LSB = 12;
  // ------------------------------------------------------------
  // Sizes and reset values
  // ------------------------------------------------------------
  localparam int NUM_SLOTS = 20;
  localparam int CMD_W = 12;
  localparam int THR_W = 16;
  localparam int OUT_W = 8;
  localparam int REG_W = 24;
  localparam int IRQ_W = 3;
  localparam logic [REG_W-1:0] RESET_REG = 24'h000000;
  localparam logic [IRQ_W-1:0] RESET_IRQ = 3'h0;
  // ------------------------------------------------------------
  // Opcodes handled here
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_WRITE = 4'h1,
    OP_GOTO = 4'h2,
    OP_COND_GOTO = 4'h3,
    OP_WINDOW = 4'h7,
    OP_HYST = 4'ha
  } opcode_t;
  // Comparison sources
  localparam logic [2:0] SRC_AMPLITUDE = 3'h0;
  localparam logic [2:0] SRC_BIN = 3'h1;
  localparam logic [2:0] SRC_DEALIAS_PHASE = 3'h2;
  localparam logic [2:0] SRC_PHASE = 3'h3;
  // Interrupt status bits
  localparam int IRQ_RISE = 0;
  localparam int IRQ_FALL = 1;
  localparam int IRQ_STEP = 2;
endpackage

// File: test/seq_asserts.sv
// Checker of bus timing and output behaviour of the sequencer
`timescale 1ns/100ps
module seq_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Sequencer
  input wire logic trigger_pulse_i,
  input wire logic compare_status_o,
  input wire logic [seq_pkg::OUT_W-1:0] control_bits_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // No step and no bus traffic, so nothing may move
  sequence quiet_s;
    !trigger_pulse_i && !(cyc_i && stb_i) && !ack_o;
  endsequence
  ack_follow_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  unmapped_zero_a: assert property (cyc_i && stb_i && !we_i && !ack_o &&
    adr_i == 8'h40 |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  reset_clear_a: assert property ($fell(rst_i) |-> !compare_status_o &&
    !irq_o && control_bits_o == 8'h00)
    else $error("outputs not cleared by reset");
  status_hold_a: assert property (quiet_s |=> $stable(compare_status_o))
    else $error("status moved without a step");
  ctrl_hold_a: assert property (quiet_s |=> $stable(control_bits_o))
    else $error("control bits moved without cause");
  irq_hold_a: assert property (quiet_s |=> $stable(irq_o))
    else $error("interrupt moved without cause");
  wr_c: cover property (cyc_i && stb_i && we_i && ack_o);
  rise_c: cover property ($rose(compare_status_o));
  irq_c: cover property ($rose(irq_o));
endmodule
bind sample_sequencer_compare seq_asserts u_seq_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .trigger_pulse_i(trigger_pulse_i), .compare_status_o(compare_status_o),
  .control_bits_o(control_bits_o), .irq_o(irq_o));

// File: test/tb.sv
// Self-checking bench of the sample sequencer
`timescale 1ns/100ps
module tb;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, trigger_pulse_i, ack_o;
  logic compare_status_o, irq_o;
  logic [7:0] adr_i, control_bits_o;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [15:0] amp, bin, dph, ph;
  int bad_count, samples_checked;
  sample_sequencer_compare u_sample_sequencer_compare (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .trigger_pulse_i(trigger_pulse_i),
    .amplitude_result_i(amp), .range_bin_index_i(bin),
    .dealias_phase_i(dph), .phase_i(ph),
    .compare_status_o(compare_status_o),
    .control_bits_o(control_bits_o), .irq_o(irq_o));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Extra edge at the end so outputs have settled on return
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      tally_and_finish();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic step(input int k);
    repeat (k) begin
      @(posedge clk_i);
      trigger_pulse_i <= 1'b1;
      @(posedge clk_i);
      trigger_pulse_i <= 1'b0;
    end
    repeat (2) @(posedge clk_i);
  endtask
  function automatic logic [31:0] ctl(input logic [3:0] f);
    return {12'h000, f, 16'd200};
  endfunction
  function automatic logic [31:0] cfg(input logic [15:0] l, input logic [2:0] s);
    return {13'h0000, l, s};
  endfunction
  // Trigger stays low across every change of the run bit
  task automatic start(input logic [11:0] c0, input logic [31:0] cf);
    wb(1'b1, 8'h14, ctl(4'h0));
    wb(1'b1, 8'h13, cf);
    wb(1'b1, 8'h15, {20'h00000, c0});
    wb(1'b1, 8'h14, ctl(4'h1));
    chk(compare_status_o, 32'h0);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_regs();
    logic [7:0] a[6] = '{8'h13, 8'h14, 8'h15, 8'h1e, 8'h20, 8'h23};
    foreach (a[i]) begin
      wb(1'b0, a[i], 32'h0);
      chk(rd, 32'h0);
    end
    wb(1'b1, 8'h13, cfg(16'hbeef, 3'h3));
    wb(1'b0, 8'h13, 32'h0);
    chk(rd, cfg(16'hbeef, 3'h3));
    wb(1'b1, 8'h14, {12'h000, 4'he, 16'h1234});
    wb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h000e1234);
    wb(1'b1, 8'h1e, 32'hff123456);
    wb(1'b0, 8'h1e, 32'h0);
    chk(rd, 32'h00123456);
    wb(1'b1, 8'h40, 32'h00ffffff);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    $display("test_regs done");
  endtask
  task automatic test_window();
    logic [15:0] v[4] = '{16'd99, 16'd100, 16'd200, 16'd201};
    logic [3:0] e = 4'b0110;
    start(12'h700, cfg(16'd100, 3'h0));
    wb(1'b0, 8'h22, 32'h0);
    foreach (v[i]) begin
      amp <= v[i];
      step(1);
      chk(compare_status_o, e[3-i]);
    end
    wb(1'b0, 8'h21, 32'h0);
    chk(rd & 32'h3e, 32'h0);
    wb(1'b1, 8'h23, 32'h0);
    chk(irq_o, 32'h0);
    wb(1'b1, 8'h23, 32'h2);
    chk(irq_o, 32'h1);
    wb(1'b0, 8'h22, 32'h0);
    chk(rd, 32'h7);
    chk(irq_o, 32'h0);
    amp <= 16'd150;
    wb(1'b1, 8'h14, ctl(4'h9));
    step(1);
    chk(compare_status_o, 32'h0);
    wb(1'b1, 8'h14, ctl(4'h1));
    step(1);
    chk(compare_status_o, 32'h1);
    $display("test_window done");
  endtask
  task automatic test_select();
    for (int s = 1; s < 4; s++) begin
      amp <= 16'd0;
      bin <= (s == 1) ? 16'd150 : 16'd0;
      dph <= (s == 2) ? 16'd150 : 16'd0;
      ph <= (s == 3) ? 16'd150 : 16'd0;
      start(12'h700, cfg(16'd100, 3'(s)));
      step(1);
      chk(compare_status_o, 32'h1);
    end
    $display("test_select done");
  endtask
  task automatic test_hyst();
    logic [15:0] v[5] = '{16'd150, 16'd200, 16'd150, 16'd100, 16'd150};
    logic [4:0] e = 5'b01100;
    start(12'ha00, cfg(16'd100, 3'h0));
    foreach (v[i]) begin
      amp <= v[i];
      step(1);
      chk(compare_status_o, e[4-i]);
    end
    $display("test_hyst done");
  endtask
  task automatic test_flow();
    start(12'h302, cfg(16'd100, 3'h0));
    wb(1'b1, 8'h16, {8'h00, 12'h203, 12'h1a5});
    wb(1'b1, 8'h20, 32'h3c);
    step(2);
    wb(1'b0, 8'h21, 32'h0);
    chk(rd & 32'h3e, 32'h0);
    wb(1'b1, 8'h14, ctl(4'h5));
    step(1);
    wb(1'b0, 8'h21, 32'h0);
    chk(rd & 32'h3e, 32'h4);
    step(1);
    chk(control_bits_o, 32'h3c);
    wb(1'b1, 8'h14, ctl(4'h7));
    chk(control_bits_o, 32'ha5);
    wb(1'b0, 8'h21, 32'h0);
    chk(rd & 32'hff3e, 32'ha506);
    $display("test_flow done");
  endtask
  // Slot 0 waits two steps, slot 1 jumps out of range back to slot 0
  task automatic test_nop();
    logic [31:0] e[3] = '{32'h0, 32'h2, 32'h0};
    start(12'h001, cfg(16'd100, 3'h0));
    wb(1'b1, 8'h15, {8'h00, 12'h2ff, 12'h001});
    foreach (e[i]) begin
      step(1);
      wb(1'b0, 8'h21, 32'h0);
      chk(rd & 32'h3e, e[i]);
    end
    $display("test_nop done");
  endtask
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'hf;
    dat_i = 32'h0;
    trigger_pulse_i = 1'b0;
    amp = 16'h0000;
    bin = 16'h0000;
    dph = 16'h0000;
    ph = 16'h0000;
    bad_count = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    test_regs();
    test_window();
    test_select();
    test_hyst();
    test_flow();
    test_nop();
    tally_and_finish();
  end
endmodule
